/* File: common/pwmcp_map.svh */
`ifndef PWMCP_MAP_SVH
`define PWMCP_MAP_SVH

// Register byte addresses.
`define PWMCP_ADDR_GP_CTRL 8'hAD
`define PWMCP_ADDR_CFG 8'hB1
`define PWMCP_ADDR_BURST 8'hB2
`define PWMCP_ADDR_DUTY 8'hB3

// General purpose control register fields.
`define PWMCP_GP_PWM_FORCE 7
`define PWMCP_GP_PWM_EN 6
`define PWMCP_GP_CV_FORCE 5
`define PWMCP_GP_CV_EN 4
`define PWMCP_GP_CV_STAT 3
`define PWMCP_GP_WR_MASK 8'hF0

// Configuration register fields.
`define PWMCP_CFG_PWM_DIV_HI 7
`define PWMCP_CFG_PWM_DIV_LO 4
`define PWMCP_CFG_CV_DIV_HI 3
`define PWMCP_CFG_CV_DIV_LO 1
`define PWMCP_CFG_SRC 0

// Reset values.
`define PWMCP_RST_GP 8'h00
`define PWMCP_RST_CFG 8'h00
`define PWMCP_RST_BURST 8'h00
`define PWMCP_RST_DUTY 8'h00

// Divider constants; contrast pulse divide is 2^(select + base), 32 to 4096.
`define PWMCP_CV_DIV_BASE 4'h5
`define PWMCP_DIV_ONE 16'h0001
`define PWMCP_ZERO16 16'h0000
`define PWMCP_ZERO8 8'h00

`endif

/* File: common/pwmcp_pkg.sv */
package pwmcp_pkg;

  typedef logic [7:0] pwmcp_byte_t;
  typedef logic [15:0] pwmcp_div_t;

  typedef enum logic [1:0] {
    CV_IDLE,
    CV_HIGH,
    CV_LOW
  } pwmcp_cv_state_e;

endpackage : pwmcp_pkg

/* File: hw/pwmcp_top.sv */
`timescale 1ns/1ps
`include "pwmcp_map.svh"

//////////////////////////////////////////////////////////////////////////////
// Function
// [RULE1] PWM output high for duty of every 256 divided clock periods; zero stays low.
// [RULE2] Duty FFh gives 255 of 256 periods high, never continuously high.
// [RULE3] Eight-bit duty register, readable and writable by software.
// [RULE4] Three-bit configuration field selects contrast pulse division of source clock.
// [RULE5] Configuration register holds PWM divide select and PWM clock source select.
// [RULE6] Control register has enable and force-high for both outputs, plus pulse status.
// [RULE7] PWM divide select is four bits, power-of-two division amounts.
// [RULE8] Force-high drives output high; neither enabled nor forced keeps it low.
module pwmcp_top
  import pwmcp_pkg::*;
(
  input wire logic clk_sys_i, // System clock, 125 MHz.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic [7:0] addr_i, // Register byte address.
  input wire logic [7:0] wr_data_i, // Write data.
  input wire logic wr_stb_i, // Write strobe, one cycle.
  input wire logic rd_stb_i, // Read strobe, one cycle.
  input wire logic alt_src_tick_i, // Alternate source clock as a one-cycle tick.
  output logic [7:0] rd_data_o, // Read data, valid the cycle after a read.
  output logic pulse_width_output_pin_o, // PWM output.
  output logic contrast_voltage_pulse_o // Contrast voltage pulse output.
);

  //////////////////////////////////////////////////////////////////////////////
  // Register file.

  pwmcp_byte_t gp_pin_status_control;
  pwmcp_byte_t pwm_contrast_pulse_config;
  pwmcp_byte_t contrast_pulse_burst_length;
  pwmcp_byte_t pwm_duty;
  pwmcp_byte_t next_gp_pin_status_control;
  pwmcp_byte_t next_pwm_contrast_pulse_config;
  pwmcp_byte_t next_contrast_pulse_burst_length;
  pwmcp_byte_t next_pwm_duty;
  pwmcp_byte_t next_rd_data;
  logic cv_busy;

  always_comb begin
    next_gp_pin_status_control = gp_pin_status_control;
    next_pwm_contrast_pulse_config = pwm_contrast_pulse_config;
    next_contrast_pulse_burst_length = contrast_pulse_burst_length;
    next_pwm_duty = pwm_duty;
    next_rd_data = `PWMCP_ZERO8;
    if (wr_stb_i) begin
      case (addr_i)
        // [RULE6] control bits written
        `PWMCP_ADDR_GP_CTRL: begin
          next_gp_pin_status_control = wr_data_i & `PWMCP_GP_WR_MASK;
        end
        // [RULE4] [RULE5] configuration write
        `PWMCP_ADDR_CFG: begin
          next_pwm_contrast_pulse_config = wr_data_i;
        end
        `PWMCP_ADDR_BURST: begin
          next_contrast_pulse_burst_length = wr_data_i;
        end
        // [RULE3] duty write
        `PWMCP_ADDR_DUTY: begin
          next_pwm_duty = wr_data_i;
        end
        default: begin
          next_pwm_duty = pwm_duty;
        end
      endcase
    end
    if (rd_stb_i) begin
      case (addr_i)
        // [RULE6] pulse status readback
        `PWMCP_ADDR_GP_CTRL: begin
          next_rd_data = gp_pin_status_control;
          next_rd_data[`PWMCP_GP_CV_STAT] = cv_busy;
        end
        `PWMCP_ADDR_CFG: begin
          next_rd_data = pwm_contrast_pulse_config;
        end
        `PWMCP_ADDR_BURST: begin
          next_rd_data = contrast_pulse_burst_length;
        end
        // [RULE3] duty readback
        `PWMCP_ADDR_DUTY: begin
          next_rd_data = pwm_duty;
        end
        default: begin
          next_rd_data = `PWMCP_ZERO8;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gp_pin_status_control <= `PWMCP_RST_GP;
      pwm_contrast_pulse_config <= `PWMCP_RST_CFG;
      contrast_pulse_burst_length <= `PWMCP_RST_BURST;
      pwm_duty <= `PWMCP_RST_DUTY;
      rd_data_o <= `PWMCP_ZERO8;
    end else begin
      gp_pin_status_control <= next_gp_pin_status_control;
      pwm_contrast_pulse_config <= next_pwm_contrast_pulse_config;
      contrast_pulse_burst_length <= next_contrast_pulse_burst_length;
      pwm_duty <= next_pwm_duty;
      rd_data_o <= next_rd_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source selection and dividers.

  // Terminal count of a divide-by-2^sel counter.
  function automatic pwmcp_div_t f_div_mask(input logic [3:0] sel);
    f_div_mask = pwmcp_div_t'((`PWMCP_DIV_ONE << sel) - `PWMCP_DIV_ONE);
  endfunction : f_div_mask

  logic src_tick;
  logic [3:0] pwm_sel;
  logic [3:0] cv_sel;
  pwmcp_div_t pwm_div_cnt;
  pwmcp_div_t cv_div_cnt;
  pwmcp_div_t next_pwm_div_cnt;
  pwmcp_div_t next_cv_div_cnt;
  logic pwm_tick;
  logic cv_tick;

  // [RULE5] source clock select
  assign src_tick = pwm_contrast_pulse_config[`PWMCP_CFG_SRC] ? alt_src_tick_i : 1'b1;
  assign pwm_sel = pwm_contrast_pulse_config[`PWMCP_CFG_PWM_DIV_HI:`PWMCP_CFG_PWM_DIV_LO];
  assign cv_sel = 4'({1'b0, pwm_contrast_pulse_config[`PWMCP_CFG_CV_DIV_HI:`PWMCP_CFG_CV_DIV_LO]})
    + `PWMCP_CV_DIV_BASE;
  // [RULE7] power-of-two PWM divide
  assign pwm_tick = src_tick && (pwm_div_cnt >= f_div_mask(pwm_sel));
  // [RULE4] contrast pulse divide
  assign cv_tick = src_tick && (cv_div_cnt >= f_div_mask(cv_sel));

  always_comb begin
    next_pwm_div_cnt = pwm_div_cnt;
    next_cv_div_cnt = cv_div_cnt;
    if (src_tick) begin
      next_pwm_div_cnt = pwm_tick ? `PWMCP_ZERO16 : pwm_div_cnt + `PWMCP_DIV_ONE;
      next_cv_div_cnt = cv_tick ? `PWMCP_ZERO16 : cv_div_cnt + `PWMCP_DIV_ONE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_div_cnt <= `PWMCP_ZERO16;
      cv_div_cnt <= `PWMCP_ZERO16;
    end else begin
      pwm_div_cnt <= next_pwm_div_cnt;
      cv_div_cnt <= next_cv_div_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // PWM output.

  pwmcp_byte_t pwm_phase;
  pwmcp_byte_t next_pwm_phase;
  logic next_pwm_out;

  always_comb begin
    next_pwm_phase = pwm_tick ? pwm_phase + 8'h01 : pwm_phase;
    // [RULE1] [RULE2] high while phase below duty
    next_pwm_out = gp_pin_status_control[`PWMCP_GP_PWM_EN] && (pwm_phase < pwm_duty);
    // [RULE8] force high wins
    if (gp_pin_status_control[`PWMCP_GP_PWM_FORCE]) begin
      next_pwm_out = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_phase <= `PWMCP_ZERO8;
      pulse_width_output_pin_o <= 1'b0;
    end else begin
      pwm_phase <= next_pwm_phase;
      pulse_width_output_pin_o <= next_pwm_out;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Contrast pulse burst.

  pwmcp_cv_state_e cv_state;
  pwmcp_cv_state_e next_cv_state;
  pwmcp_byte_t cv_left;
  pwmcp_byte_t next_cv_left;
  logic cv_en_d;
  logic cv_en;
  logic next_cv_out;

  assign cv_en = gp_pin_status_control[`PWMCP_GP_CV_EN];
  assign cv_busy = (cv_state != CV_IDLE);

  always_comb begin
    next_cv_state = cv_state;
    next_cv_left = cv_left;
    case (cv_state)
      CV_IDLE: begin
        // A burst starts once per rising edge of the enable.
        if (cv_en && !cv_en_d) begin
          next_cv_state = CV_HIGH;
          next_cv_left = contrast_pulse_burst_length;
        end
      end
      CV_HIGH: begin
        if (cv_tick) begin
          next_cv_state = CV_LOW;
        end
      end
      CV_LOW: begin
        if (cv_tick) begin
          next_cv_state = (cv_left == `PWMCP_ZERO8) ? CV_IDLE : CV_HIGH;
          next_cv_left = cv_left - 8'h01;
        end
      end
      default: begin
        next_cv_state = CV_IDLE;
      end
    endcase
    // Dropping the enable aborts a burst.
    if (!cv_en) begin
      next_cv_state = CV_IDLE;
    end
    next_cv_out = (cv_state == CV_HIGH);
    // [RULE8] force high wins
    if (gp_pin_status_control[`PWMCP_GP_CV_FORCE]) begin
      next_cv_out = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cv_state <= CV_IDLE;
      cv_left <= `PWMCP_ZERO8;
      cv_en_d <= 1'b0;
      contrast_voltage_pulse_o <= 1'b0;
    end else begin
      cv_state <= next_cv_state;
      cv_left <= next_cv_left;
      cv_en_d <= cv_en;
      contrast_voltage_pulse_o <= next_cv_out;
    end
  end

endmodule : pwmcp_top

/* File: sim/pwmcp_asserts.sv */
`timescale 1ns/1ps
module pwmcp_asserts
  import pwmcp_pkg::*;
(
  input wire logic clk_sys_i, // Clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic [7:0] addr_i, // Address.
  input wire logic [7:0] wr_data_i, // Write data.
  input wire logic wr_stb_i, // Write strobe.
  input wire logic rd_stb_i, // Read strobe.
  input wire logic alt_src_tick_i, // Alternate tick.
  input wire logic [7:0] rd_data_o, // Read data.
  input wire logic pulse_width_output_pin_o, // PWM output.
  input wire logic contrast_voltage_pulse_o // Pulse output.
);
  pwmcp_byte_t gp, cfg, duty;
  logic [9:0] run;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow copies of the control, configuration and duty registers and the length of the current high run.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gp <= 8'h00;
      cfg <= 8'h00;
      duty <= 8'h00;
      run <= 10'h000;
    end else begin
      if (wr_stb_i && addr_i == 8'hAD) gp <= wr_data_i;
      if (wr_stb_i && addr_i == 8'hB1) cfg <= wr_data_i;
      if (wr_stb_i && addr_i == 8'hB3) duty <= wr_data_i;
      run <= (pulse_width_output_pin_o && cfg == 8'h00 && !gp[7]) ? run + 10'h001 : 10'h000;
    end
  end
  sequence s_rd(a);
    rd_stb_i && addr_i == a;
  endsequence
  a_idle_read_zero: assert property (!rd_stb_i |=> rd_data_o == 8'h00)
    else $error("read data not zero outside a read");
  a_duty_readback: assert property (
    s_rd(8'hB3) |=> rd_data_o == $past(duty))
    else $error("duty read back wrong");
  a_cfg_readback: assert property (
    s_rd(8'hB1) |=> rd_data_o == $past(cfg))
    else $error("configuration read back wrong");
  a_ctrl_readback: assert property (
    s_rd(8'hAD) |=> rd_data_o[2:0] == 3'h0 && rd_data_o[7:4] == $past(gp[7:4]))
    else $error("control read back wrong");
  a_zero_duty_low: assert property (
    (duty == 8'h00 && !gp[7])[*3] |-> !pulse_width_output_pin_o)
    else $error("output high with zero duty");
  a_full_duty_gap: assert property (run <= 10'h100)
    else $error("output high too long");
  a_pwm_force_high: assert property (gp[7][*3] |-> pulse_width_output_pin_o)
    else $error("forced output low");
  a_cv_force_high: assert property (
    gp[5][*3] |-> contrast_voltage_pulse_o)
    else $error("forced pulse low");
  a_pwm_idle_low: assert property (
    (gp[7:6] == 2'h0)[*3] |-> !pulse_width_output_pin_o)
    else $error("idle output high");
  a_cv_idle_low: assert property (
    (gp[5:4] == 2'h0)[*4] |-> !contrast_voltage_pulse_o)
    else $error("idle pulse high");
endmodule : pwmcp_asserts
bind pwmcp_top pwmcp_asserts pwmcp_asserts_i (.clk_sys_i, .rst_n_i, .addr_i, .wr_data_i,
  .wr_stb_i, .rd_stb_i, .alt_src_tick_i, .rd_data_o, .pulse_width_output_pin_o,
  .contrast_voltage_pulse_o);

/* File: sim/pwmcp_panel_model.sv */
`timescale 1ns/1ps
module pwmcp_panel_model (
  input wire logic clk_sys_i, // Clock.
  input wire logic clr_i, // Clears both counters.
  input wire logic pwm_i, // PWM level seen.
  input wire logic cv_i, // Pulse level seen.
  output logic alt_tick_o, // One tick every fourth cycle.
  output logic [15:0] high_cnt_o, // Cycles with PWM high.
  output logic [7:0] edge_cnt_o // Pulse rising edges.
);
  logic [1:0] ph = 2'h0;
  logic cv_d = 1'b0;
  always_ff @(posedge clk_sys_i) begin
    ph <= ph + 2'h1;
    alt_tick_o <= (ph == 2'h3);
    cv_d <= cv_i;
    high_cnt_o <= clr_i ? 16'h0000 : high_cnt_o + {15'h0000, pwm_i};
    edge_cnt_o <= clr_i ? 8'h00 : edge_cnt_o + {7'h00, cv_i && !cv_d};
  end
endmodule : pwmcp_panel_model

/* File: sim/pwmcp_tb_top.sv */
`timescale 1ns/1ps
module pwmcp_tb_top;
  import pwmcp_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr_stb_i = 1'b0, rd_stb_i = 1'b0, clr = 1'b1;
  logic [7:0] addr_i = 8'h00, wr_data_i = 8'h00, rd_data_o, ec;
  logic pwm, cv, alt;
  logic [15:0] hc;
  int fails = 0, num_checks = 0, cyc = 0;
  pwmcp_byte_t ra[5] = '{8'hAD, 8'hB1, 8'hB2, 8'hB3, 8'hB0};
  pwmcp_byte_t dl[4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
  pwmcp_top pwmcp_top_i (.clk_sys_i, .rst_n_i, .addr_i, .wr_data_i, .wr_stb_i, .rd_stb_i,
    .alt_src_tick_i(alt), .rd_data_o, .pulse_width_output_pin_o(pwm),
    .contrast_voltage_pulse_o(cv));
  pwmcp_panel_model pwmcp_panel_model_i (.clk_sys_i, .clr_i(clr), .pwm_i(pwm), .cv_i(cv),
    .alt_tick_o(alt), .high_cnt_o(hc), .edge_cnt_o(ec));
  initial forever #4 clk_sys_i = ~clk_sys_i;
  task automatic conclude;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input pwmcp_byte_t a, input pwmcp_byte_t d);
    addr_i <= a;
    wr_data_i <= d;
    wr_stb_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_stb_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr
  task automatic rd(input pwmcp_byte_t a, input pwmcp_byte_t e);
    addr_i <= a;
    rd_stb_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_stb_i <= 1'b0;
    #1 chk("rd_data_o", {8'h00, rd_data_o}, {8'h00, e});
    @(posedge clk_sys_i);
  endtask : rd
  task automatic zap;
    repeat (4) @(posedge clk_sys_i);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
  endtask : zap
  task automatic look(input int n, input logic [15:0] h, input logic [7:0] e);
    repeat (n) @(posedge clk_sys_i);
    #1 chk("pwm_highs", hc, h);
    chk("cv_edges", {8'h00, ec}, {8'h00, e});
    @(posedge clk_sys_i);
  endtask : look
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    foreach (ra[i]) rd(ra[i], 8'h00);
    wr(8'hB2, 8'h5A);
    rd(8'hB2, 8'h5A);
    wr(8'hB1, 8'hFE);
    rd(8'hB1, 8'hFE);
    wr(8'hAD, 8'h0F);
    rd(8'hAD, 8'h00);
    wr(8'hB1, 8'h00);
    wr(8'hAD, 8'h40);
    foreach (dl[i]) begin
      wr(8'hB3, dl[i]);
      rd(8'hB3, dl[i]);
      zap();
      look(256, {8'h00, dl[i]}, 8'h00);
    end
    // Divide by four, then the external tick every fourth cycle: same high count.
    wr(8'hB1, 8'h20);
    zap();
    look(1024, 16'h03FC, 8'h00);
    wr(8'hB1, 8'h01);
    zap();
    look(1024, 16'h03FC, 8'h00);
    wr(8'hB3, 8'h00);
    wr(8'hAD, 8'hA0);
    zap();
    look(256, 16'h0100, 8'h00);
    chk("cv_level", {15'h0000, cv}, 16'h0001);
    wr(8'hAD, 8'h00);
    wr(8'hB3, 8'hFF);
    zap();
    look(256, 16'h0000, 8'h00);
    wr(8'hB1, 8'h00);
    wr(8'hB2, 8'h02);
    zap();
    wr(8'hAD, 8'h10);
    rd(8'hAD, 8'h18);
    look(400, 16'h0000, 8'h03);
    rd(8'hAD, 8'h10);
    wr(8'hAD, 8'h00);
    zap();
    wr(8'hAD, 8'h10);
    // The abort lands before a second pulse can start, so exactly one edge is seen.
    repeat (20) @(posedge clk_sys_i);
    wr(8'hAD, 8'h00);
    rd(8'hAD, 8'h00);
    look(400, 16'h0000, 8'h01);
    // Divide select 2 gives a 128-cycle pulse tick, so a pulse period of 256 cycles: a one-pulse burst ends
    // between 129 and 256 cycles after it starts.
    wr(8'hB1, 8'h04);
    wr(8'hB2, 8'h00);
    wr(8'hAD, 8'h10);
    repeat (128) @(posedge clk_sys_i);
    rd(8'hAD, 8'h18);
    repeat (126) @(posedge clk_sys_i);
    rd(8'hAD, 8'h10);
    conclude();
  end
endmodule : pwmcp_tb_top
